// >>> design/dgs_consts.svh
`ifndef DGS_CONSTS_SVH
`define DGS_CONSTS_SVH

// register indices; byte address is four times the index
`define DGS_IDX_LIVE 4'h3
`define DGS_IDX_LOGGED 4'h4
`define DGS_IDX_CTRL 4'hA
`define DGS_IDX_CFG 4'hE
`define DGS_IDX_PGSET 5'h10
`define DGS_ADDR_W 7
// control register bits
`define DGS_CTRL_RAMP 0
`define DGS_CTRL_FSHUT 1
`define DGS_CTRL_RST 8'h00
// live status bits
`define DGS_LIVE_FET 0
`define DGS_LIVE_PG 1
`define DGS_LIVE_G1 2
`define DGS_LIVE_G2 3
// logged fault bits
`define DGS_LOG_FET 0
`define DGS_LOG_OC 1
// config register: fault delay field
`define DGS_CFG_DLY_LSB 0
`define DGS_CFG_DLY_W 4
`define DGS_CFG_RST 8'h0F
`define DGS_PGSET_RST 8'h00
`define DGS_PGSET_SEQ_MASK 8'h0F
// timing
`define DGS_CLK_MHZ 10
`define DGS_PG_DELAY_US 20
`define DGS_FET_STEP_MS 1

`endif

// >>> design/dgs_pkg.sv
package dgs_pkg;
    // mode pin as decoded by the external selector comparators
    typedef enum logic [1:0] {
        DGS_MODE_PAR = 2'b00,
        DGS_MODE_HIGH = 2'b01,
        DGS_MODE_LOW = 2'b10,
        DGS_MODE_OPEN = 2'b11
    } dgs_mode_t;

    typedef enum logic [1:0] {
        DGS_ST_OFF = 2'b00,
        DGS_ST_G1 = 2'b01,
        DGS_ST_G2 = 2'b10,
        DGS_ST_PG = 2'b11
    } dgs_state_t;

    // comparator outputs, all asynchronous to clk
    typedef struct packed {
        logic fet_on;
        logic first_gate_drive_high;
        logic second_gate_drive_high;
        logic sense_a_low;
        logic vout_high;
        logic acl1;
        logic acl2;
        logic timer_trip;
    } dgs_cmp_t;
endpackage : dgs_pkg

// >>> design/dgs_sequencer.sv
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
`include "dgs_consts.svh"
// How it works
// (RULE1) mode pin at input supply selects high-stress staged sequence.
// (RULE2) at start, first gate drives on while second gate stays off.
// (RULE3) control bit picks voltage-ramp or current-limit inrush start.
// (RULE4) second gate on once first gate enhanced and sense_a low.
// (RULE5) power-good latches after second gate enhanced, sense_a low, output high.
// (RULE6) after delays, power-good outputs assert in order when setup bits zero.
// (RULE7) high-stress: second gate drops on first gate off/limit/low or sense_a high.
// (RULE8) high-stress: limit on first gate runs timer pull-up; trip ends with fault.
// (RULE9) high-stress: either gate low sets live fault flag and starts timer.
// (RULE10) fault timer expiry logs fault; shuts gates if shutdown enabled.
// (RULE11) mode pin at internal supply selects low-stress, same turn-on order.
// (RULE12) low-stress: second gate drops only with first gate; both limit together.
// (RULE13) low-stress: fault flag and timer use the parallel-mode condition.
// (RULE14) fault timer length comes from config field; software sets it long.
// (RULE15) low-stress ramp start: pull-up off unless first gate limits.
// (RULE16) low-stress after power-good: pull-up only when both gates limit.
// (RULE17) low-stress limit start: pull-up on in startup, scaled by foldback.
// (RULE18) pull-up follows first channel dissipation only, even with gate two on; low-stress uses both limits after power-good, held on in limit start.
// (RULE19) parallel condition: both gates low, or one low and not limiting.
// (RULE20) all comparator inputs pass a two-flop synchroniser first.
module dgs_sequencer #(
    parameter int FET_STEP_CYCLES = `DGS_FET_STEP_MS * 1000 * `DGS_CLK_MHZ,
    parameter int PG_DELAY_CYCLES = `DGS_PG_DELAY_US * `DGS_CLK_MHZ
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins and comparators
    input wire dgs_pkg::dgs_mode_t mode_sel,
    input wire dgs_pkg::dgs_cmp_t cmp_in,
    // gate and timer drive
    output logic first_gate_drive,
    output logic second_gate_drive,
    output logic timer_pullup_en,
    output logic timer_foldback_scale,
    // power good
    output logic power_good_internal,
    output logic power_good_out_first,
    output logic power_good_out_second,
    // avalon-mm slave
    input wire logic [`DGS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import dgs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // synchronisers
    dgs_cmp_t cmp_meta;
    dgs_cmp_t cmp;
    dgs_mode_t mode_meta;
    dgs_mode_t mode;

    // (RULE20) two-flop synchronisers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmp_meta <= '0;
            cmp <= '0;
            mode_meta <= DGS_MODE_PAR;
            mode <= DGS_MODE_PAR;
        end else begin
            cmp_meta <= cmp_in;
            cmp <= cmp_meta;
            mode_meta <= mode_sel;
            mode <= mode_meta;
        end
    end

    // (RULE1) mode decode
    logic hs;
    logic ls;
    assign hs = (mode == DGS_MODE_HIGH);
    // (RULE11) mode decode
    assign ls = (mode == DGS_MODE_LOW);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] ctrl;
    logic [7:0] cfg;
    logic [7:0] pg_setup;
    logic [1:0] logged;
    logic [7:0] live;
    logic acc;
    logic wr_acc;
    logic fet_live;
    logic fet_expire;
    logic oc_trip;

    function automatic logic hit(input logic [`DGS_ADDR_W-1:0] a, input logic [4:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction : hit

    assign acc = (avs_read || avs_write) && avs_waitrequest;
    assign wr_acc = avs_write && !avs_waitrequest;

    // one wait cycle per request, then a single-cycle acknowledge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !acc;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= `DGS_CTRL_RST;
            cfg <= `DGS_CFG_RST;
            pg_setup <= `DGS_PGSET_RST;
        end else if (wr_acc) begin
            if (hit(avs_address, {1'b0, `DGS_IDX_CTRL})) begin
                ctrl <= avs_writedata[7:0];
            end
            if (hit(avs_address, {1'b0, `DGS_IDX_CFG})) begin
                cfg <= avs_writedata[7:0];
            end
            if (hit(avs_address, `DGS_IDX_PGSET)) begin
                pg_setup <= avs_writedata[7:0];
            end
        end
    end

    // logged faults: write one to clear, a new event wins over the clear
    logic [1:0] log_clr;
    assign log_clr = (wr_acc && hit(avs_address, {1'b0, `DGS_IDX_LOGGED})) ? avs_writedata[1:0] : 2'b00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            logged <= 2'b00;
        end else begin
            // (RULE10) log on expiry
            logged[`DGS_LOG_FET] <= fet_expire || (logged[`DGS_LOG_FET] && !log_clr[`DGS_LOG_FET]);
            // (RULE8) overcurrent log
            logged[`DGS_LOG_OC] <= oc_trip || (logged[`DGS_LOG_OC] && !log_clr[`DGS_LOG_OC]);
        end
    end

    // unmapped addresses read zero and ignore writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (acc) begin
            avs_readdata <= 32'h0000_0000;
            if (hit(avs_address, {1'b0, `DGS_IDX_LIVE})) begin
                avs_readdata[7:0] <= live;
            end
            if (hit(avs_address, {1'b0, `DGS_IDX_LOGGED})) begin
                avs_readdata[1:0] <= logged;
            end
            if (hit(avs_address, {1'b0, `DGS_IDX_CTRL})) begin
                avs_readdata[7:0] <= ctrl;
            end
            if (hit(avs_address, {1'b0, `DGS_IDX_CFG})) begin
                avs_readdata[7:0] <= cfg;
            end
            if (hit(avs_address, `DGS_IDX_PGSET)) begin
                avs_readdata[7:0] <= pg_setup;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gate sequence
    dgs_state_t state;
    dgs_state_t next_state;
    logic fault_hold;
    logic run_ok;
    logic g2_drop;

    // a logged overcurrent, or a logged transistor fault with shutdown, keeps gates off until cleared
    assign fault_hold = logged[`DGS_LOG_OC] || (logged[`DGS_LOG_FET] && ctrl[`DGS_CTRL_FSHUT]);
    assign run_ok = cmp.fet_on && (hs || ls) && !fault_hold;
    assign oc_trip = (state != DGS_ST_OFF) && cmp.timer_trip;
    // (RULE7) second gate protection
    assign g2_drop = hs && (!cmp.first_gate_drive_high || cmp.acl1 || !cmp.sense_a_low);

    always_comb begin
        next_state = state;
        case (state)
            // (RULE2) first gate first
            DGS_ST_OFF: begin
                if (run_ok) begin
                    next_state = DGS_ST_G1;
                end
            end
            // (RULE4) second gate after enhancement
            DGS_ST_G1: begin
                if (cmp.first_gate_drive_high && cmp.sense_a_low && !g2_drop) begin
                    next_state = DGS_ST_G2;
                end
            end
            // (RULE5) latch power good
            DGS_ST_G2: begin
                if (g2_drop) begin
                    next_state = DGS_ST_G1;
                end else if (cmp.second_gate_drive_high && cmp.sense_a_low && cmp.vout_high) begin
                    next_state = DGS_ST_PG;
                end
            end
            // (RULE12) low-stress keeps gate two with gate one
            DGS_ST_PG: begin
                if (g2_drop) begin
                    next_state = DGS_ST_G1;
                end
            end
            default: next_state = DGS_ST_OFF;
        endcase
        // (RULE8) trip and shutdown override
        if (!run_ok || oc_trip || fet_expire && ctrl[`DGS_CTRL_FSHUT]) begin
            next_state = DGS_ST_OFF;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= DGS_ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            first_gate_drive <= 1'b0;
            second_gate_drive <= 1'b0;
        end else begin
            first_gate_drive <= (next_state != DGS_ST_OFF);
            second_gate_drive <= (next_state == DGS_ST_G2) || (next_state == DGS_ST_PG);
        end
    end

    // internal power good stays latched until the gates turn off
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            power_good_internal <= 1'b0;
        end else if (next_state == DGS_ST_OFF) begin
            power_good_internal <= 1'b0;
        end else if (next_state == DGS_ST_PG) begin
            power_good_internal <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // breaker timer pull-up; channel one current limit feeds it, except low-stress after power good (both limits needed) and low-stress limit start (held on)
    logic ramp_inrush_select;
    logic ls_climit_start;
    assign ramp_inrush_select = ctrl[`DGS_CTRL_RAMP];
    // (RULE3) inrush mode choice
    assign ls_climit_start = ls && !ramp_inrush_select && !power_good_internal && (state != DGS_ST_OFF);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer_pullup_en <= 1'b0;
            timer_foldback_scale <= 1'b0;
        end else begin
            timer_pullup_en <= 1'b0;
            timer_foldback_scale <= ls_climit_start;
            if (state != DGS_ST_OFF) begin
                // (RULE18) channel one only
                if (hs) begin
                    timer_pullup_en <= cmp.acl1;
                end else if (ls && power_good_internal) begin
                    // (RULE16) both gates limiting
                    timer_pullup_en <= cmp.acl1 && cmp.acl2;
                end else if (ls_climit_start) begin
                    // (RULE17) on during start, scaled
                    timer_pullup_en <= 1'b1;
                end else if (ls) begin
                    // (RULE15) ramp start, only on limit
                    timer_pullup_en <= cmp.acl1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transistor fault detection and timer
    logic [31:0] fet_cnt;
    logic [31:0] fet_limit;
    logic bad_hs;
    logic bad_ls;

    // (RULE9) either gate low
    assign bad_hs = hs && (!cmp.first_gate_drive_high || !cmp.second_gate_drive_high);
    // (RULE13) parallel-style condition
    // (RULE19) both low, or one low without limit
    assign bad_ls = ls && ((!cmp.first_gate_drive_high && !cmp.second_gate_drive_high) || (!cmp.first_gate_drive_high && !cmp.acl1)
                    || (!cmp.second_gate_drive_high && !cmp.acl2));
    assign fet_live = (state != DGS_ST_OFF) && (bad_hs || bad_ls);
    // (RULE14) delay from config field
    assign fet_limit = 32'(cfg[`DGS_CFG_DLY_LSB +: `DGS_CFG_DLY_W]) * 32'(FET_STEP_CYCLES);
    assign fet_expire = fet_live && (fet_cnt >= fet_limit) && (fet_cnt != 32'hFFFF_FFFF);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fet_cnt <= 32'h0000_0000;
        end else if (!fet_live) begin
            fet_cnt <= 32'h0000_0000;
        end else if (fet_expire) begin
            fet_cnt <= 32'hFFFF_FFFF;
        end else if (fet_cnt != 32'hFFFF_FFFF) begin
            fet_cnt <= fet_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            live <= 8'h00;
        end else begin
            live <= 8'h00;
            live[`DGS_LIVE_FET] <= fet_live;
            live[`DGS_LIVE_PG] <= power_good_internal;
            live[`DGS_LIVE_G1] <= first_gate_drive;
            live[`DGS_LIVE_G2] <= second_gate_drive;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequential power-good outputs
    logic [31:0] pg_cnt;
    logic pg_seq;
    assign pg_seq = ((pg_setup & `DGS_PGSET_SEQ_MASK) == 8'h00) && power_good_internal;

    // (RULE6) delayed, in order
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pg_cnt <= 32'h0000_0000;
            power_good_out_first <= 1'b0;
            power_good_out_second <= 1'b0;
        end else if (!pg_seq) begin
            pg_cnt <= 32'h0000_0000;
            power_good_out_first <= 1'b0;
            power_good_out_second <= 1'b0;
        end else if (!power_good_out_second) begin
            if (pg_cnt == 32'(PG_DELAY_CYCLES - 1)) begin
                pg_cnt <= 32'h0000_0000;
                power_good_out_first <= 1'b1;
                power_good_out_second <= power_good_out_first;
            end else begin
                pg_cnt <= pg_cnt + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_g2_needs_g1;
        second_gate_drive |-> first_gate_drive;
    endproperty
    a_g2_needs_g1: assert property (p_g2_needs_g1) else $error("second gate without first"); // RULE2

    property p_g2_on;
        (state == DGS_ST_G1) && run_ok && !oc_trip && !fet_expire && !g2_drop && cmp.first_gate_drive_high && cmp.sense_a_low
            |=> second_gate_drive;
    endproperty
    a_g2_on: assert property (p_g2_on) else $error("second gate did not turn on"); // RULE4

    property p_g2_drop_hs;
        second_gate_drive && hs && cmp.acl1 |=> !second_gate_drive;
    endproperty
    a_g2_drop_hs: assert property (p_g2_drop_hs) else $error("second gate kept in limit"); // RULE7

    property p_g2_keep_ls;
        ls && second_gate_drive && run_ok && !oc_trip && !fet_expire |=> second_gate_drive;
    endproperty
    a_g2_keep_ls: assert property (p_g2_keep_ls) else $error("second gate dropped alone"); // RULE12

    property p_trip_off;
        oc_trip |=> !first_gate_drive && logged[`DGS_LOG_OC];
    endproperty
    a_trip_off: assert property (p_trip_off) else $error("trip did not stop gates"); // RULE8

    property p_pullup_hs;
        hs && (state != DGS_ST_OFF) |=> timer_pullup_en == $past(cmp.acl1);
    endproperty
    a_pullup_hs: assert property (p_pullup_hs) else $error("pull-up not following limit"); // RULE18

    property p_pullup_run_ls;
        ls && power_good_internal && (state != DGS_ST_OFF) |=> timer_pullup_en == $past(cmp.acl1 && cmp.acl2);
    endproperty
    a_pullup_run_ls: assert property (p_pullup_run_ls) else $error("pull-up running wrong"); // RULE16

    property p_fet_log;
        fet_expire |=> logged[`DGS_LOG_FET] ##1 (!ctrl[`DGS_CTRL_FSHUT] || !first_gate_drive);
    endproperty
    a_fet_log: assert property (p_fet_log) else $error("fault expiry not handled"); // RULE10

    property p_pg_order;
        $rose(power_good_out_second) |-> $past(power_good_out_first, 1);
    endproperty
    a_pg_order: assert property (p_pg_order) else $error("power good out of order"); // RULE6

    property p_live_flag;
        fet_live |=> live[`DGS_LIVE_FET];
    endproperty
    a_live_flag: assert property (p_live_flag) else $error("live flag missing"); // RULE9

    c_pg: cover property (power_good_out_second);
    c_trip: cover property (oc_trip);
    c_fet: cover property (fet_expire);
    c_hs_drop: cover property (hs && $fell(second_gate_drive) && first_gate_drive);

endmodule : dgs_sequencer

// >>> sim/dgs_fet_model.sv
`timescale 1ns/10ps
//////////////////////////////
module dgs_fet_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // gate drive from the sequencer
    input wire logic first_gate_drive,
    input wire logic second_gate_drive,
    // bench controls
    input wire logic fet_on,
    input wire logic trip,
    input wire logic short_en,
    input wire logic g1_dead,
    input wire logic slow,
    // comparator view
    output dgs_pkg::dgs_cmp_t cmp
);
    import dgs_pkg::*;
    logic [3:0] rise1;
    logic [3:0] rise2;
    logic [3:0] target;
    logic charged;
    assign target = slow ? 4'h8 : 4'h2;
    //////////////////////////////
    // gates charge over a few cycles; a dead first transistor never enhances
    always_ff @(posedge clk) begin
        if (!rst_n || !first_gate_drive) begin
            rise1 <= 4'h0;
        end else if (rise1 < target) begin
            rise1 <= rise1 + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n || !second_gate_drive) begin
            rise2 <= 4'h0;
        end else if (rise2 < target) begin
            rise2 <= rise2 + 4'h1;
        end
    end
    // a shorted output pulls every enhanced gate back into limit
    assign charged = (rise1 >= target) && !g1_dead && !short_en;
    always_comb begin
        cmp.fet_on = fet_on;
        cmp.first_gate_drive_high = charged;
        cmp.second_gate_drive_high = (rise2 >= target) && !short_en;
        cmp.sense_a_low = charged;
        cmp.vout_high = charged;
        cmp.acl1 = short_en && first_gate_drive;
        cmp.acl2 = short_en && second_gate_drive;
        cmp.timer_trip = trip;
    end
endmodule : dgs_fet_model

// >>> sim/dual_gate_staged_start_sequencer_tb_top.sv
`timescale 1ns/10ps
//////////////////////////////
module dual_gate_staged_start_sequencer_tb_top;
    import dgs_pkg::*;
    localparam int STEP = 4;
    logic clk, rst_n, fet_on, trip, short_en, g1_dead, slow;
    dgs_mode_t mode_sel;
    dgs_cmp_t cmp_in;
    logic first_gate_drive, second_gate_drive, timer_pullup_en, timer_foldback_scale;
    logic power_good_internal, power_good_out_first, power_good_out_second;
    logic [6:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, rd, seed, field;
    int n_mismatch, compares, cycles, pu_cnt, fold_cnt, mark, pu_mark;

    dgs_sequencer #(.FET_STEP_CYCLES(STEP), .PG_DELAY_CYCLES(3)) dut_u (.clk(clk), .rst_n(rst_n),
        .mode_sel(mode_sel), .cmp_in(cmp_in), .first_gate_drive(first_gate_drive),
        .second_gate_drive(second_gate_drive), .timer_pullup_en(timer_pullup_en),
        .timer_foldback_scale(timer_foldback_scale), .power_good_internal(power_good_internal),
        .power_good_out_first(power_good_out_first), .power_good_out_second(power_good_out_second),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    dgs_fet_model fet_u (.clk(clk), .rst_n(rst_n), .first_gate_drive(first_gate_drive),
        .second_gate_drive(second_gate_drive), .fet_on(fet_on), .trip(trip), .short_en(short_en),
        .g1_dead(g1_dead), .slow(slow), .cmp(cmp_in));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    //////////////////////////////
    // the hang limit is far above the few hundred cycles the scenarios need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (timer_pullup_en === 1'b1) pu_cnt <= pu_cnt + 1;
        if (timer_foldback_scale === 1'b1) fold_cnt <= fold_cnt + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            conclude();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic pick(input int w);
        case (w)
            0: return first_gate_drive;
            1: return second_gate_drive;
            2: return power_good_internal;
            3: return power_good_out_first;
            4: return power_good_out_second;
            default: return timer_pullup_en;
        endcase
    endfunction : pick
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // request held until waitrequest is sampled low at an edge
    task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        // no local limit: a slave that never answers is caught by the cycle ceiling
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wait_v(input string name, input int w, input logic v, input int lim);
        int n;
        n = 0;
        while (pick(w) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk(name, {31'h0, v}, {31'h0, pick(w)});
    endtask : wait_v
    task automatic start(input dgs_mode_t m);
        @(posedge clk);
        mode_sel <= m;
        fet_on <= 1'b1;
        wait_v("first gate on", 0, 1'b1, 20);
        chk("second gate at start", 0, second_gate_drive);
        wait_v("second gate on", 1, 1'b1, 40);
        chk("gate one enhanced", 1, cmp_in.first_gate_drive_high & cmp_in.sense_a_low);
        wait_v("power good latch", 2, 1'b1, 40);
        chk("out first early", 0, power_good_out_first);
        wait_v("power good first", 3, 1'b1, 20);
        chk("out second early", 0, power_good_out_second);
        wait_v("power good second", 4, 1'b1, 20);
    endtask : start
    task automatic stop_all;
        @(posedge clk);
        fet_on <= 1'b0;
        short_en <= 1'b0;
        trip <= 1'b0;
        g1_dead <= 1'b0;
        slow <= 1'b0;
        mode_sel <= DGS_MODE_PAR;
        wait_v("first gate off", 0, 1'b0, 20);
        wait_v("second gate off", 1, 1'b0, 20);
        bus(1'b1, 7'h10, 32'h0000_0003, rd);
    endtask : stop_all
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    //////////////////////////////
    initial begin
        {rst_n, fet_on, trip, short_en, g1_dead, slow, avs_read, avs_write} = 8'h00;
        mode_sel = DGS_MODE_PAR;
        avs_address = 7'h00;
        avs_writedata = 32'h0000_0000;
        {n_mismatch, compares, cycles, pu_cnt, fold_cnt} = '0;
        seed = 32'h0000_DB74;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("waitrequest idle", 1, avs_waitrequest);
        bus(1'b0, 7'h38, 32'h0, rd);
        chk("config reset", 32'h0000_000F, rd);
        bus(1'b0, 7'h28, 32'h0, rd);
        chk("control reset", 0, rd);
        bus(1'b0, 7'h40, 32'h0, rd);
        chk("pg setup reset", 0, rd);
        bus(1'b1, 7'h0C, 32'h0000_00FF, rd);
        bus(1'b0, 7'h0C, 32'h0, rd);
        chk("live status read only", 0, rd);
        bus(1'b0, 7'h7C, 32'h0, rd);
        chk("unmapped read", 0, rd);
        // the open pin code never sequences the gates here; the fixed seed picks open on all four passes
        repeat (4) begin
            seed = xs(seed);
            @(posedge clk);
            mode_sel <= seed[0] ? DGS_MODE_OPEN : DGS_MODE_PAR;
            fet_on <= 1'b1;
            repeat (10) @(posedge clk);
            chk("gate in other mode", 0, first_gate_drive);
        end
        fet_on <= 1'b0;
        start(DGS_MODE_HIGH);
        bus(1'b0, 7'h0C, 32'h0, rd);
        chk("live power good", 1, rd[1]);
        @(posedge clk);
        short_en <= 1'b1;
        wait_v("second gate dropped", 1, 1'b0, 8);
        wait_v("pull-up in limit", 5, 1'b1, 8);
        chk("first gate kept", 1, first_gate_drive);
        @(posedge clk);
        trip <= 1'b1;
        wait_v("first gate tripped", 0, 1'b0, 8);
        trip <= 1'b0;
        bus(1'b0, 7'h10, 32'h0, rd);
        chk("overcurrent logged", 1, rd[1]);
        bus(1'b1, 7'h10, 32'h0000_0002, rd);
        bus(1'b0, 7'h10, 32'h0, rd);
        chk("overcurrent cleared", 0, rd[1]);
        stop_all();
        seed = xs(seed);
        field = 32'h2 + {30'h0, seed[1:0]};
        bus(1'b1, 7'h38, field, rd);
        bus(1'b1, 7'h28, 32'h0000_0002, rd);
        @(posedge clk);
        g1_dead <= 1'b1;
        mode_sel <= DGS_MODE_HIGH;
        fet_on <= 1'b1;
        wait_v("first gate on", 0, 1'b1, 20);
        bus(1'b0, 7'h0C, 32'h0, rd);
        chk("live fault flag", 1, rd[0]);
        wait_v("gates shut on fault", 0, 1'b0, int'(field) * STEP + 20);
        bus(1'b0, 7'h10, 32'h0, rd);
        chk("fault logged", 1, rd[0]);
        stop_all();
        bus(1'b1, 7'h28, 32'h0000_0001, rd);
        bus(1'b1, 7'h38, 32'h0000_000F, rd);
        mark = pu_cnt;
        start(DGS_MODE_LOW);
        chk("pull-up in ramp start", mark, pu_cnt);
        bus(1'b1, 7'h40, 32'h0000_0001, rd);
        repeat (2) @(posedge clk);
        chk("out first gated by setup", 0, power_good_out_first);
        bus(1'b1, 7'h40, 32'h0000_0000, rd);
        @(posedge clk);
        short_en <= 1'b1;
        wait_v("pull-up both limit", 5, 1'b1, 8);
        repeat (4) @(posedge clk);
        chk("second gate kept", 1, second_gate_drive);
        stop_all();
        bus(1'b1, 7'h28, 32'h0000_0000, rd);
        mark = fold_cnt;
        pu_mark = pu_cnt;
        slow <= 1'b1;
        start(DGS_MODE_LOW);
        chk("foldback in limit start", 1, fold_cnt > mark);
        chk("pull-up in limit start", 1, pu_cnt > pu_mark);
        stop_all();
        @(posedge clk);
        g1_dead <= 1'b1;
        mode_sel <= DGS_MODE_LOW;
        fet_on <= 1'b1;
        wait_v("first gate on", 0, 1'b1, 20);
        repeat (4) @(posedge clk);
        bus(1'b0, 7'h0C, 32'h0, rd);
        chk("low stress fault flag", 1, rd[0]);
        stop_all();
        conclude();
    end
endmodule : dual_gate_staged_start_sequencer_tb_top
